// ### pkg/nav_codec_defs.vh
// Constants for the navigation packet payload codec.
// Assumes inclusion by bare name from design files.
`ifndef NAV_CODEC_DEFS_VH
`define NAV_CODEC_DEFS_VH
`define ID_BODY_ACCEL     8'h26
`define ID_EULER          8'h27
`define ID_QUAT           8'h28
`define ID_DCM            8'h29
`define ID_ANG_VEL        8'h2A
`define ID_ANG_ACC        8'h2B
`define ID_EXT_POS_VEL    8'h2C
`define ID_EXT_POS        8'h2D
`define LEN_BODY_ACCEL    8'h10
`define LEN_EULER         8'h0C
`define LEN_QUAT          8'h10
`define LEN_DCM           8'h24
`define LEN_ANG_VEL       8'h0C
`define LEN_ANG_ACC       8'h0C
`define LEN_EXT_POS_VEL   8'h3C
`define LEN_EXT_POS       8'h24
`define OFF_EXT_VEL       8'h18
`define OFF_EXT_POS_DEV   8'h24
`define OFF_EXT_VEL_DEV   8'h30
`define OFF_EXT_POS_ONLY_DEV 8'h18
`endif

// ### design/nav_skid_buffer.v
// Two-entry valid/ready buffer for payload bytes plus framing flags.
// Assumes source and sink share sys_clk.
`timescale 1ns/10ps
module nav_skid_buffer #(
    parameter WIDTH = 18
) (
    input  wire             sys_clk,
    input  wire             reset,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem_ff [0:1];
    reg             wr_ptr_ff;
    reg             rd_ptr_ff;
    reg [1:0]       count_ff;
    wire            push;
    wire            pop;

    assign in_ready  = (count_ff != 2'h2);
    assign out_valid = (count_ff != 2'h0);
    assign out_data  = mem_ff[rd_ptr_ff];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            case ({push, pop})
                2'b10:   count_ff <= count_ff + 2'h1;
                2'b01:   count_ff <= count_ff - 2'h1;
                default: count_ff <= count_ff;
            endcase
        end
    end
endmodule

// ### design/nav_packet_payload_codec.v
// Payload encoder and decoder for navigation packets 38 to 45.
// Assumes header, checksum and link timing are handled outside; bytes stream in and out.
`timescale 1ns/10ps
`include "nav_codec_defs.vh"
module nav_packet_payload_codec (
    input  wire         sys_clk,
    input  wire         reset,
    // Encoder request: id selects packet, words are fp32 fields
    input  wire         tx_req,
    input  wire [7:0]   tx_id,
    input  wire [287:0] tx_words,
    output wire         tx_busy,
    output wire [7:0]   tx_len,
    output wire [7:0]   tx_data,
    output wire         tx_first,
    output wire         tx_last,
    output wire         tx_valid,
    input  wire         tx_ready,
    // Decoder byte stream
    input  wire [7:0]   rx_id,
    input  wire [7:0]   rx_len,
    input  wire [7:0]   rx_data,
    input  wire         rx_first,
    input  wire         rx_last,
    input  wire         rx_valid,
    output wire         rx_ready,
    // Stored external data
    output reg  [63:0]  ext_lat,
    output reg  [63:0]  ext_lon,
    output reg  [63:0]  ext_hgt,
    output reg  [95:0]  ext_vel,
    output reg  [95:0]  ext_pos_dev,
    output reg  [95:0]  ext_vel_dev,
    output reg          ext_pos_update,
    output reg          ext_vel_update,
    output reg          ext_discard
);
    localparam ST_IDLE = 1'b0;
    localparam ST_SEND = 1'b1;

    reg         state_ff;
    reg [287:0] shift_ff;
    reg [7:0]   len_ff;
    reg [7:0]   cnt_ff;
    wire        buf_in_ready;
    wire [17:0] buf_out;

    function [7:0] payload_len;
        input [7:0] id;
        begin
            case (id)
                `ID_BODY_ACCEL:  payload_len = `LEN_BODY_ACCEL;
                `ID_EULER:       payload_len = `LEN_EULER;
                `ID_QUAT:        payload_len = `LEN_QUAT;
                `ID_DCM:         payload_len = `LEN_DCM;
                `ID_ANG_VEL:     payload_len = `LEN_ANG_VEL;
                `ID_ANG_ACC:     payload_len = `LEN_ANG_ACC;
                `ID_EXT_POS_VEL: payload_len = `LEN_EXT_POS_VEL;
                `ID_EXT_POS:     payload_len = `LEN_EXT_POS;
                default:         payload_len = 8'h00;
            endcase
        end
    endfunction

    // Only output packets 38..43 are encoded; others are ignored
    wire tx_id_ok = (tx_id >= `ID_BODY_ACCEL) && (tx_id <= `ID_ANG_ACC);

    assign tx_busy = (state_ff == ST_SEND);
    assign tx_len  = len_ff;

    // Word k of tx_words is field k in payload order, so byte n is bits [8n+7:8n]
    always @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            shift_ff <= 288'h0;
            len_ff   <= 8'h00;
            cnt_ff   <= 8'h00;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (tx_req && tx_id_ok) begin
                        shift_ff <= tx_words;
                        len_ff   <= payload_len(tx_id);
                        cnt_ff   <= 8'h00;
                        state_ff <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (buf_in_ready) begin
                        shift_ff <= {8'h00, shift_ff[287:8]};
                        cnt_ff   <= cnt_ff + 8'h01;
                        if (cnt_ff == len_ff - 8'h01) begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Buffer keeps bytes safe while the link stalls
    nav_skid_buffer #(
        .WIDTH (18)
    ) u_buf (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .in_data   ({8'h00, (cnt_ff == 8'h00), (cnt_ff == len_ff - 8'h01), shift_ff[7:0]}),
        .in_valid  (state_ff == ST_SEND),
        .in_ready  (buf_in_ready),
        .out_data  (buf_out),
        .out_valid (tx_valid),
        .out_ready (tx_ready)
    );
    assign tx_data  = buf_out[7:0];
    assign tx_last  = buf_out[8];
    assign tx_first = buf_out[9];

    // Decoder: gather into a staging area, commit only on a good ending
    reg [479:0] stage_ff;
    reg [7:0]   rx_cnt_ff;
    reg         bad_ff;
    wire [7:0]  rx_pos    = rx_first ? 8'h00 : rx_cnt_ff;
    wire        rx_id_ok  = (rx_id == `ID_EXT_POS_VEL) || (rx_id == `ID_EXT_POS);
    wire        len_ok    = (rx_len == payload_len(rx_id)) && (rx_pos + 8'h01 == rx_len);
    wire [479:0] full_stage;

    assign rx_ready = 1'b1;
    // Incoming byte lands at its own offset, little-endian
    assign full_stage = (stage_ff & ~({472'h0, 8'hFF} << {rx_pos, 3'b000}))
                      | ({472'h0, rx_data} << {rx_pos, 3'b000});

    always @(posedge sys_clk) begin
        if (reset) begin
            stage_ff       <= 480'h0;
            rx_cnt_ff      <= 8'h00;
            bad_ff         <= 1'b0;
            ext_lat        <= 64'h0;
            ext_lon        <= 64'h0;
            ext_hgt        <= 64'h0;
            ext_vel        <= 96'h0;
            ext_pos_dev    <= 96'h0;
            ext_vel_dev    <= 96'h0;
            ext_pos_update <= 1'b0;
            ext_vel_update <= 1'b0;
            ext_discard    <= 1'b0;
        end else begin
            ext_pos_update <= 1'b0;
            ext_vel_update <= 1'b0;
            ext_discard    <= 1'b0;
            if (rx_valid && rx_id_ok) begin
                if (rx_pos < 8'h3C) begin
                    stage_ff <= full_stage;
                end
                rx_cnt_ff <= rx_pos + 8'h01;
                bad_ff    <= rx_first ? (rx_pos >= 8'h3C) : (bad_ff | (rx_pos >= 8'h3C));
                if (rx_last) begin
                    rx_cnt_ff <= 8'h00;
                    // Overlong or short payloads never reach the stored data
                    if (!len_ok || bad_ff) begin
                        ext_discard <= 1'b1;
                    end else begin
                        ext_lat        <= full_stage[63:0];
                        ext_lon        <= full_stage[127:64];
                        ext_hgt        <= full_stage[191:128];
                        ext_pos_update <= 1'b1;
                        if (rx_id == `ID_EXT_POS_VEL) begin
                            ext_vel        <= full_stage[`OFF_EXT_VEL*8 +: 96];
                            ext_pos_dev    <= full_stage[`OFF_EXT_POS_DEV*8 +: 96];
                            ext_vel_dev    <= full_stage[`OFF_EXT_VEL_DEV*8 +: 96];
                            ext_vel_update <= 1'b1;
                        end else begin
                            ext_pos_dev <= full_stage[`OFF_EXT_POS_ONLY_DEV*8 +: 96];
                        end
                    end
                end
            end
        end
    end
endmodule

// ### verif/nav_codec_asserts.sv
// Checker for the payload codec port behaviour.
// Assumes it is bound to the codec top and sees only its ports.
`timescale 1ns/10ps
module nav_codec_asserts (
    input wire         sys_clk,
    input wire         reset,
    input wire         tx_req,
    input wire [7:0]   tx_id,
    input wire         tx_busy,
    input wire [7:0]   tx_len,
    input wire [7:0]   tx_data,
    input wire         tx_first,
    input wire         tx_last,
    input wire         tx_valid,
    input wire         tx_ready,
    input wire         rx_valid,
    input wire         rx_last,
    input wire [63:0]  ext_lat,
    input wire [95:0]  ext_pos_dev,
    input wire         ext_pos_update,
    input wire         ext_vel_update,
    input wire         ext_discard
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // Start is only checked from an empty buffer, else old bytes may lead
    a_start_stream: assert property (tx_req && !tx_busy && !tx_valid && tx_id == 8'h2A
        |=> tx_busy ##1 tx_valid && tx_first) else $error("encode start late");
    a_dcm_len: assert property (tx_req && !tx_busy && !tx_valid && tx_id == 8'h29
        |-> ##2 tx_len == 8'h24) else $error("matrix length wrong");
    a_stall_hold: assert property (tx_valid && !tx_ready
        |=> tx_valid && $stable({tx_data, tx_first, tx_last})) else $error("byte lost in stall");
    a_frame_next: assert property (tx_valid && tx_ready && tx_last
        |=> !tx_valid || tx_first) else $error("frame not restarted");
    a_vel_pair: assert property (ext_vel_update |-> ext_pos_update) else $error("velocity alone");
    a_store_cause: assert property ($changed(ext_lat) || $changed(ext_pos_dev)
        |-> ext_pos_update) else $error("store without update");
    a_result_cause: assert property (ext_pos_update || ext_discard
        |-> $past(rx_valid && rx_last)) else $error("result without last byte");
    a_one_verdict: assert property (ext_discard
        |-> !ext_pos_update && !ext_vel_update) else $error("discard and update");
endmodule
bind nav_packet_payload_codec nav_codec_asserts chk (.sys_clk, .reset, .tx_req, .tx_id, .tx_busy, .tx_len,
    .tx_data, .tx_first, .tx_last, .tx_valid, .tx_ready, .rx_valid, .rx_last, .ext_lat, .ext_pos_dev,
    .ext_pos_update, .ext_vel_update, .ext_discard);

// ### verif/nav_host_model.sv
// Host model: sinks encoder bytes, sources decoder payload bytes.
// Assumes a shared sys_clk; drives change at the falling edge.
`timescale 1ns/10ps
module nav_host_model (
    input  wire       sys_clk,
    input  wire       slow,
    output reg        tx_ready,
    output reg  [7:0] rx_data,
    output reg        rx_first,
    output reg        rx_last,
    output reg        rx_valid
);
    reg [1:0] cnt_ff = 2'h0;
    initial begin
        tx_ready = 1'b1;
        {rx_data, rx_first, rx_last, rx_valid} = 11'h000;
    end
    // Slow mode accepts one byte in four
    always @(negedge sys_clk) begin
        cnt_ff <= cnt_ff + 2'h1;
        tx_ready <= !slow || cnt_ff == 2'h3;
    end
    // Byte k of the payload is bits 8k+7..8k, lowest byte first
    task send(input [479:0] pl, input [7:0] n);
        integer k;
        for (k = 0; k < n; k = k + 1) begin
            @(negedge sys_clk);
            rx_data = pl[8*k +: 8];
            rx_first = k == 0;
            rx_last = k == n - 1;
            rx_valid = 1'b1;
        end
        @(negedge sys_clk);
        rx_valid = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

// ### verif/tb_top.sv
// Bench: encoder bytes and decoder store checked against expectation queues.
// Assumes the host model drives tx_ready and the decoder byte stream.
`timescale 1ns/10ps
module tb_top;
    localparam [47:0] lens = 48'h100C10240C0C;
    reg          sys_clk  = 1'b0;
    reg          reset    = 1'b1;
    reg          tx_req   = 1'b0;
    reg          slow     = 1'b0;
    reg  [7:0]   tx_id    = 8'h00;
    reg  [7:0]   rx_id    = 8'h00;
    reg  [7:0]   rx_len   = 8'h00;
    reg  [287:0] tx_words = 288'h0;
    reg  [31:0]  seed     = 32'hA8A83E54;
    reg  [479:0] pl;
    reg  [63:0]  e_lat    = 64'h0;
    reg  [63:0]  e_lon    = 64'h0;
    reg  [63:0]  e_hgt    = 64'h0;
    reg  [95:0]  e_vel    = 96'h0;
    reg  [95:0]  e_pdev   = 96'h0;
    reg  [95:0]  e_vdev   = 96'h0;
    reg  [9:0]   txq[$];
    reg  [481:0] rxq[$];
    integer      n_fail   = 0;
    integer      checks   = 0;
    integer      i, j, k, s;
    wire [7:0]   tx_len, tx_data, rx_data;
    wire         tx_busy, tx_first, tx_last, tx_valid, tx_ready, rx_first, rx_last, rx_valid, rx_ready;
    wire [63:0]  ext_lat, ext_lon, ext_hgt;
    wire [95:0]  ext_vel, ext_pos_dev, ext_vel_dev;
    wire         ext_pos_update, ext_vel_update, ext_discard;
    always #50 sys_clk = ~sys_clk;
    nav_packet_payload_codec dut (.sys_clk, .reset, .tx_req, .tx_id, .tx_words, .tx_busy, .tx_len, .tx_data,
        .tx_first, .tx_last, .tx_valid, .tx_ready, .rx_id, .rx_len, .rx_data, .rx_first, .rx_last, .rx_valid,
        .rx_ready, .ext_lat, .ext_lon, .ext_hgt, .ext_vel, .ext_pos_dev, .ext_vel_dev, .ext_pos_update,
        .ext_vel_update, .ext_discard);
    nav_host_model hm (.sys_clk, .slow, .tx_ready, .rx_data, .rx_first, .rx_last, .rx_valid);
    function [31:0] rnd(input [31:0] v);
        rnd = v ^ (v << 13);
        rnd = rnd ^ (rnd >> 17);
        rnd = rnd ^ (rnd << 5);
    endfunction
    task cmp(input [95:0] what, input [481:0] exp, input [481:0] got);
        checks = checks + 1;
        if (exp !== got) begin
            n_fail = n_fail + 1;
            $display("mismatch %0s expected %h seen %h", what, exp, got);
        end
    endtask
    task end_sim;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task fill;
        for (k = 0; k < 60; k = k + 1) begin
            seed = rnd(seed);
            pl[8*k +: 8] = seed[7:0];
        end
        tx_words = pl[287:0];
    endtask
    task enc(input [7:0] id, input [7:0] n);
        fill;
        for (k = 0; k < n; k = k + 1)
            txq.push_back({k == 0, k == n - 1, pl[8*k +: 8]});
        tx_id = id;
        tx_req = 1'b1;
        @(negedge sys_clk);
        tx_req = 1'b0;
        for (i = 0; i < 300 && (tx_busy || txq.size() > 0); i = i + 1)
            @(negedge sys_clk);
        if (i == 300) begin
            n_fail = n_fail + 1;
            end_sim;
        end
        if (n != 0)
            cmp("tx len", n, tx_len);
        else
            cmp("tx busy", 0, tx_busy);
        $display("test tx %h done", id);
    endtask
    // A dropped packet expects the last good store to remain
    task rcv(input [7:0] id, input [7:0] len, input [7:0] n, input ok);
        fill;
        if (ok) begin
            e_lat = pl[63:0];
            e_lon = pl[127:64];
            e_hgt = pl[191:128];
            if (id == 8'h2C) begin
                e_vel  = pl[287:192];
                e_pdev = pl[383:288];
                e_vdev = pl[479:384];
            end else begin
                e_pdev = pl[287:192];
            end
        end
        rxq.push_back({e_lat, e_lon, e_hgt, e_vel, e_pdev, e_vdev, ok && id == 8'h2C, !ok});
        rx_id = id;
        rx_len = len;
        hm.send(pl, n);
        repeat (2) @(negedge sys_clk);
        $display("test rx %h done", id);
    endtask
    always @(posedge sys_clk) begin
        if (!reset && tx_valid && tx_ready)
            cmp("tx byte", txq.pop_front(), {tx_first, tx_last, tx_data});
        if (!reset && (ext_pos_update || ext_discard))
            cmp("ext store", rxq.pop_front(), {ext_lat, ext_lon, ext_hgt, ext_vel, ext_pos_dev, ext_vel_dev,
                ext_vel_update, ext_discard});
    end
    initial begin
        repeat (12) @(negedge sys_clk);
        reset = 1'b0;
        for (s = 0; s < 2; s = s + 1) begin
            slow = s[0];
            for (j = 0; j < 6; j = j + 1)
                enc(8'h26 + j[7:0], lens[47 - 8 * j -: 8]);
        end
        enc(8'h2C, 8'h00);
        rcv(8'h2C, 8'h3C, 8'h3C, 1'b1);
        rcv(8'h2D, 8'h24, 8'h24, 1'b1);
        rcv(8'h2D, 8'h3C, 8'h24, 1'b0);
        rcv(8'h2C, 8'h3C, 8'h3B, 1'b0);
        rcv(8'h2C, 8'h3C, 8'h3C, 1'b1);
        cmp("rx left", 0, rxq.size());
        end_sim;
    end
endmodule
